/* File: ats_pkg.sv */
// Package for the antenna training sequencer: constants, states and frame descriptors.
// Assumes a single 100 MHz clock domain and a register port with one-cycle read latency.
package ats_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  // Clock period in ps.
  localparam int unsigned CLK_PERIOD_PS = 10000;
  // Reply window in ns, counted from the end of our training frame.
  localparam int unsigned REPLY_WINDOW_NS = 10000;
  // Reply window in cycles, rounded down.
  localparam int unsigned REPLY_WINDOW_CYC = (REPLY_WINDOW_NS * 1000) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------------------
  // Protocol figures
  // ---------------------------------------------------------------------------
  // Spreading factor used while nothing is trained.
  localparam logic [7:0] SF_INITIAL = 8'h80;
  // Spreading factor in the final iteration.
  localparam logic [7:0] SF_FINAL = 8'h04;
  // Number of iterations at most.
  localparam logic [2:0] ITER_MAX = 3'h4;
  // Columns of the tracking training matrix.
  localparam logic [7:0] TRACK_COLS = 8'h03;
  // Feedback status meaning done.
  localparam logic STATUS_DONE = 1'b0;
  // Feedback methods during tracking.
  localparam logic [1:0] FB_METHOD_INDEX = 2'h1;
  localparam logic [1:0] FB_METHOD_WEIGHTS = 2'h2;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ANT = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_WEIGHT = 4'h3;
  // Control field positions.
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_OPEN_BIT = 1;
  localparam int unsigned CTRL_TRACK_BIT = 2;
  localparam int unsigned CTRL_RENEG_BIT = 3;
  localparam int unsigned CTRL_PEER_A_BIT = 4;
  localparam int unsigned CTRL_ABORT_BIT = 5;
  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ANT_RESET = 32'h0000_0000;
  localparam logic [31:0] WEIGHT_RESET = 32'h0000_0000;

  // Sequencer states.
  typedef enum logic [2:0] {
    ATS_IDLE,
    ATS_SEND,
    ATS_WAIT,
    ATS_FINAL_FB,
    ATS_TRACK_REQ,
    ATS_TRACK_CONF,
    ATS_TRACK_SEND
  } ats_state_t;

  // Descriptor of a frame that we ask the transmitter to send.
  typedef struct packed {
    logic [2:0] iteration;
    logic [7:0] spreading_factor;
    logic [7:0] rx_training_symbol_count;
    logic [7:0] tx_training_symbol_count;
    logic [7:0] requested_spreading_factor;
    logic [7:0] requested_rx_symbol_count;
    logic with_feedback;
    logic with_request;
    logic use_fed_back_weights;
    logic [1:0] feedback_method;
  } ats_tx_frame_t;

  // Descriptor of a frame received from the peer.
  typedef struct packed {
    logic [2:0] iteration;
    logic has_feedback;
    logic has_request;
    logic feedback_status;
    logic [7:0] requested_spreading_factor;
    logic [7:0] requested_rx_symbol_count;
    logic [31:0] tx_weights;
  } ats_rx_frame_t;

endpackage

/* File: ats_sequencer.sv */
// Operation
// - Exchange training parameters before iterations start.
// - Feedback element may ride inside training frame.
// - Iteration 0 sends peer-antenna receive symbols, spreading 128.
// - First frame carries matrix-column transmit symbols.
// - Request spreading 128 for peer first reply.
// - Request one receive symbol per own antenna.
// - Transmit with spreading factor peer requested.
// - Iteration 1 uses peer requested spreading factor.
// - Later frames use fed-back weights except matrix symbols.
// - Later frames carry requested count and feedback.
// - Later iterations repeat pattern, at most four.
// - Send final feedback after last iteration.
// - Open loop omits feedback, reuses receive weights.
// - Tracking skips handshake, adds training segment.
// - Reused tracking config starts sending sequences.
// - Renegotiation sends request, peer confirms next.
// - After renegotiation, send sequences in segment.
// - Tracking one iteration; method by peer type.
// - Tracking matrix has three sweep columns.
// - Iteration counter clears, increments on feedback; code steps on any accepted reply while all_done is clear, with or without feedback.
// - Final iteration uses spreading factor four.
// - Stop after four iterations or both done.
//
// Training sequencer on the initiating station S.
// Assumes frame descriptors come from logic on the same clock and that
// the handshake finished before software sets the start bit.
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none

module ats_sequencer
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Transmit request towards the frame builder.
  output logic tx_req_o,
  output ats_pkg::ats_tx_frame_t tx_frame_o,
  output logic [31:0] tx_weights_o,
  input wire logic tx_done_i,
  // Received frame from the peer.
  input wire logic rx_valid_i,
  input wire ats_pkg::ats_rx_frame_t rx_frame_i
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Control register; start and abort bits are self-clearing.
  logic [31:0] ctrl_q;
  // Antenna counts: [7:0] own, [15:8] peer, [23:16] matrix columns.
  logic [31:0] ant_q;
  // Current transmit weights.
  logic [31:0] weight_q;
  // Sequencer state.
  ats_pkg::ats_state_t state_q;
  ats_pkg::ats_state_t state_d;
  // Iteration counter.
  logic [2:0] iter_q;
  // Spreading factor and count requested by the peer.
  logic [7:0] peer_sf_q;
  logic [7:0] peer_cnt_q;
  // Peer reported done in its last accepted reply.
  logic peer_done_q;
  // Reply window counter.
  logic [15:0] wait_q;
  // Sticky flag for an abandoned iteration.
  logic timeout_q;
  // Read data register.
  logic [31:0] rdata_q;

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  // Register write selects.
  wire logic wr_ctrl = reg_wr_i && (reg_addr_i == ats_pkg::REG_CTRL);
  wire logic wr_ant = reg_wr_i && (reg_addr_i == ats_pkg::REG_ANT);
  // Control bits as named levels.
  wire logic go = ctrl_q[ats_pkg::CTRL_START_BIT];
  wire logic open_loop = ctrl_q[ats_pkg::CTRL_OPEN_BIT];
  wire logic track = ctrl_q[ats_pkg::CTRL_TRACK_BIT];
  wire logic reneg = ctrl_q[ats_pkg::CTRL_RENEG_BIT];
  wire logic abort = ctrl_q[ats_pkg::CTRL_ABORT_BIT];
  // Antenna counts split into their fields.
  wire logic [7:0] own_ant = ant_q[7:0];
  wire logic [7:0] peer_ant = ant_q[15:8];
  wire logic [7:0] mat_cols = ant_q[23:16];
  // Last iteration is the fourth, numbered three.
  wire logic last_iter = (iter_q == (ats_pkg::ITER_MAX - 3'h1));
  // Reply matches our iteration number.
  wire logic rx_match = rx_valid_i && (rx_frame_i.iteration == iter_q);
  wire logic wait_over = (wait_q == 16'(ats_pkg::REPLY_WINDOW_CYC));
  // A reply that lands with a timeout or abort is dropped, so nothing advances.
  wire logic rx_take = (state_q == ats_pkg::ATS_WAIT) && rx_match && !abort && !wait_over;
  // Both ends done when peer reported done or this is the last step.
  wire logic all_done = peer_done_q || last_iter;

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  // Control bits; start and abort clear in the first cycle without a control write.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= ats_pkg::CTRL_RESET;
      ant_q <= ats_pkg::ANT_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata_i;
      else
      begin
        ctrl_q[ats_pkg::CTRL_START_BIT] <= 1'b0;
        ctrl_q[ats_pkg::CTRL_ABORT_BIT] <= 1'b0;
      end
      if (wr_ant)
        ant_q <= reg_wdata_i;
    end
  end

  // ---------------------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------------------
  // Next-state logic.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ats_pkg::ATS_IDLE:
      begin
        if (go && track && reneg)
          state_d = ats_pkg::ATS_TRACK_REQ;
        else if (go && track)
          state_d = ats_pkg::ATS_TRACK_SEND;
        else if (go)
          state_d = ats_pkg::ATS_SEND;
      end
      ats_pkg::ATS_SEND:
        if (tx_done_i)
          state_d = ats_pkg::ATS_WAIT;
      ats_pkg::ATS_WAIT:
      begin
        if (abort || wait_over)
          state_d = ats_pkg::ATS_IDLE;
        else if (rx_match && all_done)
          state_d = open_loop ? ats_pkg::ATS_IDLE : ats_pkg::ATS_FINAL_FB;
        else if (rx_match)
          state_d = ats_pkg::ATS_SEND;
      end
      ats_pkg::ATS_FINAL_FB:
        if (tx_done_i)
          state_d = ats_pkg::ATS_IDLE;
      ats_pkg::ATS_TRACK_REQ:
        if (tx_done_i)
          state_d = ats_pkg::ATS_TRACK_CONF;
      ats_pkg::ATS_TRACK_CONF:
      begin
        if (abort || wait_over)
          state_d = ats_pkg::ATS_IDLE;
        else if (rx_valid_i && rx_frame_i.has_request)
          state_d = ats_pkg::ATS_TRACK_SEND;
      end
      ats_pkg::ATS_TRACK_SEND:
        if (tx_done_i)
          state_d = ats_pkg::ATS_IDLE;
      default:
        state_d = ats_pkg::ATS_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_q <= ats_pkg::ATS_IDLE;
    else
      state_q <= state_d;
  end

  // Iteration counter: cleared at start, advanced on an accepted reply unless all_done is set.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      iter_q <= 3'h0;
    else if (state_q == ats_pkg::ATS_IDLE && go)
      iter_q <= 3'h0;
    else if (rx_take && !all_done)
      iter_q <= iter_q + 3'h1;
  end

  // Peer requests and weights captured from replies.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      peer_sf_q <= ats_pkg::SF_INITIAL;
      peer_cnt_q <= 8'h00;
      peer_done_q <= 1'b0;
      weight_q <= ats_pkg::WEIGHT_RESET;
    end
    else if (state_q == ats_pkg::ATS_IDLE && go)
    begin
      peer_sf_q <= ats_pkg::SF_INITIAL;
      peer_cnt_q <= peer_ant;
      peer_done_q <= 1'b0;
    end
    else if (rx_take)
    begin
      peer_sf_q <= rx_frame_i.requested_spreading_factor;
      peer_cnt_q <= rx_frame_i.requested_rx_symbol_count;
      peer_done_q <= rx_frame_i.has_feedback &&
        (rx_frame_i.feedback_status == ats_pkg::STATUS_DONE);
      if (rx_frame_i.has_feedback && !open_loop)
        weight_q <= rx_frame_i.tx_weights;
    end
  end

  // Reply window counter, restarted whenever a wait begins.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      wait_q <= 16'h0000;
    else if (state_q == ats_pkg::ATS_WAIT || state_q == ats_pkg::ATS_TRACK_CONF)
      wait_q <= wait_over ? wait_q : wait_q + 16'h0001;
    else
      wait_q <= 16'h0000;
  end

  // Sticky abandon flag; a new timeout wins over a software clear.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      timeout_q <= 1'b0;
    else if (wait_over)
      timeout_q <= 1'b1;
    else if (reg_wr_i && reg_addr_i == ats_pkg::REG_STATUS)
      timeout_q <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Frame descriptor
  // ---------------------------------------------------------------------------
  wire logic in_send = (state_q == ats_pkg::ATS_SEND);
  wire logic in_track = (state_q == ats_pkg::ATS_TRACK_SEND);
  wire logic first_iter = (iter_q == 3'h0);
  // Fourth iteration, numbered three, uses the smallest spreading factor in ATS_SEND; the closing ATS_FINAL_FB frame keeps peer_sf_q.
  wire logic [7:0] sf_now = (in_send && last_iter) ? ats_pkg::SF_FINAL : peer_sf_q;
  wire logic [1:0] fb_method = ctrl_q[ats_pkg::CTRL_PEER_A_BIT] ?
    ats_pkg::FB_METHOD_WEIGHTS : ats_pkg::FB_METHOD_INDEX;

  // Descriptor for the frame builder.
  always_comb
  begin
    tx_frame_o = '0;
    tx_frame_o.iteration = iter_q;
    tx_frame_o.spreading_factor = sf_now;
    tx_frame_o.rx_training_symbol_count = first_iter ? peer_ant : peer_cnt_q;
    tx_frame_o.tx_training_symbol_count = in_track ? ats_pkg::TRACK_COLS : mat_cols;
    tx_frame_o.requested_spreading_factor = ats_pkg::SF_INITIAL;
    tx_frame_o.requested_rx_symbol_count = own_ant;
    tx_frame_o.with_feedback = !open_loop && !in_track;
    tx_frame_o.with_request = (state_q == ats_pkg::ATS_TRACK_REQ);
    tx_frame_o.use_fed_back_weights = !first_iter && !open_loop;
    tx_frame_o.feedback_method = fb_method;
  end

  // Request is held until the frame builder reports the frame sent.
  assign tx_req_o = in_send || in_track ||
    (state_q == ats_pkg::ATS_FINAL_FB) || (state_q == ats_pkg::ATS_TRACK_REQ);
  assign tx_weights_o = weight_q;

  // ---------------------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------------------
  wire logic [31:0] status_word = {22'h000000, timeout_q, peer_done_q,
    1'b0, iter_q, 1'b0, 3'(state_q)};
  wire logic [31:0] rd_mux =
    (reg_addr_i == ats_pkg::REG_CTRL) ? ctrl_q :
    (reg_addr_i == ats_pkg::REG_ANT) ? ant_q :
    (reg_addr_i == ats_pkg::REG_STATUS) ? status_word :
    (reg_addr_i == ats_pkg::REG_WEIGHT) ? weight_q : 32'h0000_0000;

  // Read data one cycle after the strobe, zero otherwise.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end
  assign reg_rdata_o = rdata_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence s_sent;
    state_q == ats_pkg::ATS_SEND && tx_done_i;
  endsequence

  // A reply that is accepted and moves training on.
  sequence s_fed;
    rx_take && !all_done;
  endsequence

  first_sf_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (in_send && first_iter) |-> tx_frame_o.spreading_factor == ats_pkg::SF_INITIAL)
    else $error("First frame spreading wrong.");
  iter_cap_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    iter_q < ats_pkg::ITER_MAX) else $error("Iteration above limit.");
  final_sf_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (in_send && last_iter) |-> tx_frame_o.spreading_factor == ats_pkg::SF_FINAL)
    else $error("Final spreading wrong.");
  no_advance_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state_q == ats_pkg::ATS_WAIT && wait_over) |=> state_q == ats_pkg::ATS_IDLE && $stable(iter_q))
    else $error("Timeout advanced iteration.");
  open_fb_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (tx_req_o && open_loop) |-> !tx_frame_o.with_feedback) else $error("Open loop feedback.");
  track_cols_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    in_track |-> tx_frame_o.tx_training_symbol_count == ats_pkg::TRACK_COLS)
    else $error("Tracking columns wrong.");
  send_wait_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_sent |=> state_q == ats_pkg::ATS_WAIT ##1 wait_q == 16'h0001)
    else $error("Reply wait not started.");
  weight_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(state_q == ats_pkg::ATS_WAIT && rx_match) |=> $stable(weight_q))
    else $error("Weights changed early.");
  iter_step_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_fed |=> iter_q == $past(iter_q) + 3'h1)
    else $error("Iteration did not advance.");
  track_once_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (in_track && tx_done_i) |=> state_q == ats_pkg::ATS_IDLE)
    else $error("Tracking ran more than once.");
  timeout_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wait_over |=> timeout_q)
    else $error("Timeout flag not set.");

endmodule // ats_sequencer

`default_nettype wire

/* File: ats_peer_model.sv */
// Peer station model that answers the training sequencer's frames.
// Assumes the sequencer's clock and that the bench sets the silent and done controls.
`timescale 1ns/10ps
`default_nettype none

module ats_peer_model
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic tx_req_i,
  input wire ats_pkg::ats_tx_frame_t tx_frame_i,
  input wire logic silent_i,
  input wire logic done_i,
  output logic tx_done_o,
  output logic rx_valid_o,
  output ats_pkg::ats_rx_frame_t rx_frame_o
);
  // ---------------------------------------------------------------------------
  // Frame service
  // ---------------------------------------------------------------------------
  // Copy of the frame being answered.
  ats_pkg::ats_tx_frame_t f;
  // Reply under construction.
  ats_pkg::ats_rx_frame_t r;

  // Quiet outputs at time zero.
  initial
  begin
    tx_done_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_frame_o = '0;
  end

  // Sends each requested frame, then answers it unless told to stay silent.
  always
  begin
    @(posedge core_clk_i);
    if (!rst_i && tx_req_i)
    begin
      f = tx_frame_i;
      repeat (3) @(posedge core_clk_i);
      tx_done_o <= 1'b1;
      @(posedge core_clk_i);
      tx_done_o <= 1'b0;
      // A silent peer lets the reply window run out.
      if (!silent_i)
      begin
        r.iteration = f.iteration;
        r.has_feedback = f.with_feedback;
        r.has_request = f.with_request;
        r.feedback_status = done_i ? ats_pkg::STATUS_DONE : ~ats_pkg::STATUS_DONE;
        r.requested_spreading_factor = 8'h80 >> (f.iteration + 3'h1);
        r.requested_rx_symbol_count = 8'h03;
        r.tx_weights = {29'h0000_0540, f.iteration};
        // The reply lands well inside the short interframe space.
        repeat (20) @(posedge core_clk_i);
        rx_frame_o <= r;
        rx_valid_o <= 1'b1;
        @(posedge core_clk_i);
        rx_valid_o <= 1'b0;
        // Released lines show the inverse of the last reply.
        rx_frame_o <= ~r;
      end
    end
  end
endmodule // ats_peer_model

`default_nettype wire

/* File: test_ats_sequencer.sv */
// Self-checking bench for the training sequencer with a peer model.
// Assumes one 100 MHz clock and the register map of the sequencer package.
`timescale 1ns/10ps
`default_nettype none

module test_ats_sequencer;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic tx_req_o;
  ats_pkg::ats_tx_frame_t tx_frame_o;
  logic [31:0] tx_weights_o;
  logic tx_done_i;
  logic rx_valid_i;
  ats_pkg::ats_rx_frame_t rx_frame_i;
  logic silent = 1'b0;
  logic peer_done = 1'b0;
  int n_fail = 0;
  int compares = 0;
  // Frames and weights seen during one session.
  ats_pkg::ats_tx_frame_t fr [8];
  logic [31:0] wt [8];
  int n;
  logic [31:0] rd;

  always #5 core_clk_i = ~core_clk_i;

  ats_sequencer i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tx_req_o(tx_req_o), .tx_frame_o(tx_frame_o),
    .tx_weights_o(tx_weights_o), .tx_done_i(tx_done_i), .rx_valid_i(rx_valid_i),
    .rx_frame_i(rx_frame_i));

  ats_peer_model i_peer (.core_clk_i(core_clk_i), .rst_i(rst_i), .tx_req_i(tx_req_o),
    .tx_frame_i(tx_frame_o), .silent_i(silent), .done_i(peer_done), .tx_done_o(tx_done_i),
    .rx_valid_o(rx_valid_i), .rx_frame_o(rx_frame_i));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle register write.
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // One-cycle register read; data are taken in the cycle after the strobe.
  task automatic reg_read(input logic [3:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    rd = reg_rdata_o;
  endtask

  // Starts a session and records up to eight frames until the sequencer stays quiet.
  task automatic run(input logic [31:0] ctrl);
    int idle;
    logic prev;
    n = 0;
    idle = 0;
    prev = 1'b0;
    reg_write(ats_pkg::REG_CTRL, ctrl);
    while (idle < 1200)
    begin
      @(negedge core_clk_i);
      if (tx_req_o === 1'b1)
      begin
        idle = 0;
        if (prev !== 1'b1 && n < 8)
        begin
          fr[n] = tx_frame_o;
          wt[n] = tx_weights_o;
          n++;
        end
      end
      else
        idle++;
      prev = tx_req_o;
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Reset values and an unmapped read.
  task automatic t_reset;
    reg_read(ats_pkg::REG_CTRL);
    chk("ctrl", ats_pkg::CTRL_RESET, rd);
    reg_read(ats_pkg::REG_ANT);
    chk("ant", ats_pkg::ANT_RESET, rd);
    reg_read(ats_pkg::REG_WEIGHT);
    chk("weight", ats_pkg::WEIGHT_RESET, rd);
    reg_read(4'hf);
    chk("unmapped", 32'h0000_0000, rd);
    chk("tx_req idle", 32'h0, {31'h0, tx_req_o});
  endtask

  // Full closed-loop session: four iterations and a closing feedback frame.
  task automatic t_closed;
    reg_write(ats_pkg::REG_ANT, 32'h0002_0604);
    run(32'h0000_0001);
    chk("frames", 32'h5, n);
    chk("iter0", 32'h0, fr[0].iteration);
    chk("sf0", 32'h80, fr[0].spreading_factor);
    chk("rxcnt0", 32'h6, fr[0].rx_training_symbol_count);
    chk("txcnt0", 32'h2, fr[0].tx_training_symbol_count);
    chk("reqsf0", 32'h80, fr[0].requested_spreading_factor);
    chk("reqrx0", 32'h4, fr[0].requested_rx_symbol_count);
    chk("fb0", 32'h1, fr[0].with_feedback);
    for (int k = 1; k < 4; k++)
    begin
      chk("iter", k, fr[k].iteration);
      chk("sf", (k == 3) ? 32'h4 : (32'h80 >> k), fr[k].spreading_factor);
      chk("rxcnt", 32'h3, fr[k].rx_training_symbol_count);
      chk("txcnt", 32'h2, fr[k].tx_training_symbol_count);
      chk("fedback", 32'h1, fr[k].use_fed_back_weights);
      chk("fb", 32'h1, fr[k].with_feedback);
      chk("weights", {29'h0000_0540, 3'(k - 1)}, wt[k]);
    end
    chk("final fb", 32'h1, fr[4].with_feedback);
    reg_read(ats_pkg::REG_STATUS);
    chk("iter end", 32'h3, rd[6:4]);
    chk("state end", {29'h0, ats_pkg::ATS_IDLE}, rd[2:0]);
  endtask

  // Open loop: no feedback element and no closing frame.
  task automatic t_open;
    run(32'h0000_0003);
    chk("open frames", 32'h4, n);
    for (int k = 0; k < 4; k++)
      chk("open fb", 32'h0, fr[k].with_feedback);
  endtask

  // Peer reports done in its first reply; the session closes one iteration later.
  task automatic t_done;
    peer_done <= 1'b1;
    run(32'h0000_0001);
    chk("done frames", 32'h3, n);
    chk("done fb", 32'h1, fr[2].with_feedback);
    reg_read(ats_pkg::REG_STATUS);
    chk("peer done", 32'h1, rd[8]);
    chk("done iter", 32'h1, rd[6:4]);
    peer_done <= 1'b0;
  endtask

  // Silent peer: the iteration is dropped and the sticky flag clears on write.
  task automatic t_timeout;
    silent <= 1'b1;
    run(32'h0000_0001);
    chk("to frames", 32'h1, n);
    reg_read(ats_pkg::REG_STATUS);
    chk("to flag", 32'h1, rd[9]);
    chk("to iter", 32'h0, rd[6:4]);
    chk("to state", {29'h0, ats_pkg::ATS_IDLE}, rd[2:0]);
    reg_write(ats_pkg::REG_STATUS, 32'h0000_0000);
    reg_read(ats_pkg::REG_STATUS);
    chk("to clear", 32'h0, rd[9]);
    // A software abort inside the reply window drops the wait with no timeout.
    reg_write(ats_pkg::REG_CTRL, 32'h0000_0001);
    repeat (20) @(posedge core_clk_i);
    reg_write(ats_pkg::REG_CTRL, 32'h0000_0020);
    repeat (1100) @(posedge core_clk_i);
    reg_read(ats_pkg::REG_STATUS);
    chk("ab state", {29'h0, ats_pkg::ATS_IDLE}, rd[2:0]);
    chk("ab flag", 32'h0, rd[9]);
    chk("ab iter", 32'h0, rd[6:4]);
    silent <= 1'b0;
  endtask

  // Tracking with the last configuration, for both peer types.
  task automatic t_track;
    for (int a = 0; a < 2; a++)
    begin
      run(32'h0000_0005 | (a << ats_pkg::CTRL_PEER_A_BIT));
      chk("trk frames", 32'h1, n);
      chk("trk cols", ats_pkg::TRACK_COLS, fr[0].tx_training_symbol_count);
      chk("trk req", 32'h0, fr[0].with_request);
      chk("trk method", (a == 1) ? ats_pkg::FB_METHOD_WEIGHTS : ats_pkg::FB_METHOD_INDEX,
        fr[0].feedback_method);
    end
  endtask

  // Tracking with renegotiation: request first, sequences after confirmation.
  task automatic t_reneg;
    run(32'h0000_000d);
    chk("rn frames", 32'h2, n);
    chk("rn req", 32'h1, fr[0].with_request);
    chk("rn seq req", 32'h0, fr[1].with_request);
    chk("rn cols", ats_pkg::TRACK_COLS, fr[1].tx_training_symbol_count);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_closed();
    t_open();
    t_done();
    t_timeout();
    t_track();
    t_reneg();
    finish_test();
  end

  // Cuts a hang short well after the expected run time.
  initial
  begin
    #400000;
    n_fail++;
    finish_test();
  end
endmodule // test_ats_sequencer

`default_nettype wire
